//--- bridge_pwm_pkg.sv
// package for the enhanced bridge pwm output stage: register map, fields, resets
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package bridge_pwm_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CONTROL  = 4'h0;
    localparam logic [3:0] OFS_PERIOD   = 4'h4;
    localparam logic [3:0] OFS_DUTY     = 4'h8;
    localparam logic [3:0] OFS_STATUS   = 4'hc;
    // control register field positions
    localparam int CTL_ENABLE_BIT  = 0;
    localparam int CTL_ARR_LSB     = 1;     // bridge_arrangement_select, 2 bits
    localparam int CTL_POL_LSB     = 4;     // unit_function_polarity_select, 2 bits
    localparam int CTL_PRESC_LSB   = 8;     // prescaler code, 2 bits
    localparam int CTL_OE_LSB      = 12;    // pin_direction_control, 4 bits
    // reset values
    localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
    localparam logic [9:0]  PERIOD_RST  = 10'h3ff;
    localparam logic [9:0]  DUTY_RST    = 10'h000;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
    // duty resolution in bits
    localparam int DUTY_BITS = 10;

    // output arrangements, bit 1 of the code is the full-bridge direction
    typedef enum logic [1:0] {
        ARR_SINGLE  = 2'b00,
        ARR_FULL_FW = 2'b01,
        ARR_HALF    = 2'b10,
        ARR_FULL_RV = 2'b11
    } arrangement_e;

    // full-bridge direction sequencer
    typedef enum logic [1:0] {
        DIR_IDLE   = 2'b00,
        DIR_RUN    = 2'b01,
        DIR_TURN   = 2'b10
    } dir_state_e;
endpackage

//--- bridge_pwm.sv
// enhanced bridge pwm output stage with avalon-mm register access
// assumes one clock, synchronous active-low reset, pin drivers outside the block
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module bridge_pwm #(
    parameter int PERIOD_WIDTH = bridge_pwm_pkg::DUTY_BITS
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // pwm pins, output enable low while driving
    output logic             pwm_output_a,
    output logic             pwm_output_b,
    output logic             pwm_output_c,
    output logic             pwm_output_d,
    output logic [3:0]       pwm_output_oe_b
);

    typedef struct packed {
        logic [31:0]                    control;
        logic [PERIOD_WIDTH-1:0]        period;
        logic [PERIOD_WIDTH-1:0]        duty;
        logic [PERIOD_WIDTH-1:0]        duty_live;
        logic [PERIOD_WIDTH-1:0]        count;
        logic [7:0]                     presc;
        logic                           running;
        logic                           fw_live;
        bridge_pwm_pkg::dir_state_e     dstate;
        logic [31:0]                    rdata;
        logic                           ack;
        logic                           waitreq;
        logic [3:0]                     pin;
        logic [3:0]                     oe_b;
    } state_s;

    state_s cur_ff;
    state_s nxt_st;

    // decoded control fields
    logic                         enable;
    bridge_pwm_pkg::arrangement_e arr;
    logic [1:0]                   pol;
    logic [1:0]                   presc_code;
    logic [3:0]                   pin_dir;
    logic [7:0]                   presc_lim;
    logic                         presc_tick;
    logic                         period_end;
    logic                         full_mode;
    logic                         want_fw;
    logic                         mod_on;
    logic                         act_ac;
    logic                         act_bd;
    logic [3:0]                   used;
    logic [3:0]                   level;
    logic [31:0]                  wmask;

    // field decode; polarity bit 0 = a/c active low, bit 1 = b/d active low
    // the prescaler divides the system clock before the period timer steps:
    //   code 0 steps every clock, code 1 every 4, code 2 every 16, code 3 every 64
    // the prescaler keeps running while the stage is disabled, so the first
    // period after enable may start at any phase of it; the stage waits for
    // the wrap anyway, so no short first pulse can reach a pin
    // a code change in mid-period takes effect at once; a prescale count that is
    // already above the new limit simply ticks on the next clock
    always_comb begin
        enable     = cur_ff.control[bridge_pwm_pkg::CTL_ENABLE_BIT];
        arr        = bridge_pwm_pkg::arrangement_e'(
                         cur_ff.control[bridge_pwm_pkg::CTL_ARR_LSB +: 2]);
        pol        = cur_ff.control[bridge_pwm_pkg::CTL_POL_LSB +: 2];
        presc_code = cur_ff.control[bridge_pwm_pkg::CTL_PRESC_LSB +: 2];
        pin_dir    = cur_ff.control[bridge_pwm_pkg::CTL_OE_LSB +: 4];
        full_mode  = arr[0];
        want_fw    = (arr == bridge_pwm_pkg::ARR_FULL_FW);
        // prescale of 1, 4, 16 or 64 system clocks per timer step
        case (presc_code)
            2'b00:   presc_lim = 8'h00;
            2'b01:   presc_lim = 8'h03;
            2'b10:   presc_lim = 8'h0f;
            default: presc_lim = 8'h3f;
        endcase
        presc_tick = (cur_ff.presc >= presc_lim);
        period_end = presc_tick && (cur_ff.count >= cur_ff.period);
    end

    // byte-enable write mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{byteenable[i]}};
        end
    end

    // waveform levels before polarity: ac = held leg, bd = modulated leg
    // single: a carries the pulse, b c d are released to other pin functions
    // half: a carries the pulse, b is its complement while running; no dead band,
    //   so a half-bridge user with slow switch turn-off must add it outside
    // full: one held leg and one modulated leg on opposite sides of the bridge;
    //   only the modulated output switches in the run state, which is why no dead band is needed there
    // levels are computed here and registered in the pin flops, so every pin
    // change appears one clock after the state that causes it
    always_comb begin
        mod_on = cur_ff.running && (cur_ff.dstate == bridge_pwm_pkg::DIR_RUN)
                 && (cur_ff.count < cur_ff.duty_live);
        used   = 4'h0;
        level  = 4'h0;
        act_ac = 1'b0;
        act_bd = 1'b0;
        case (arr)
            bridge_pwm_pkg::ARR_SINGLE: begin
                used  = 4'b0001;
                level = {3'b000, mod_on};
            end
            bridge_pwm_pkg::ARR_HALF: begin
                used  = 4'b0011;
                level = {2'b00, ~mod_on & cur_ff.running, mod_on};
            end
            default: begin
                used  = 4'b1111;
                // held leg follows the live direction, swapped at turn start
                act_ac = cur_ff.running;
                act_bd = mod_on; // modulated leg inactive during turn
                if (cur_ff.fw_live) begin
                    level = {act_bd, 1'b0, 1'b0, act_ac}; // d mod, a held
                end else begin
                    level = {1'b0, act_ac, act_bd, 1'b0}; // c held, b mod
                end
                // direct switching with no dead-band delay
            end
        endcase
    end

    // next-state logic: bus slave, timer, direction sequencer, pins
    always_comb begin
        nxt_st     = cur_ff;
        nxt_st.ack = 1'b0;
        // bus slave timing, as the master sees it:
        //   cycle 0: request arrives, waitrequest still high from idle
        //   cycle 1: ack flop set, waitrequest low, read data standing
        //   edge ending cycle 1: a write lands and the master lets go
        // a request still held after that edge starts over with waitrequest high,
        // so back-to-back transfers take two cycles each
        // unmapped reads give zero, unmapped writes are dropped; there is no error
        if ((read || write) && !cur_ff.ack) begin
            nxt_st.ack = 1'b1;
            // writes leave readdata alone so it only moves on a read answer
            if (read) begin
                case (address)
                    bridge_pwm_pkg::OFS_CONTROL: nxt_st.rdata = cur_ff.control;
                    bridge_pwm_pkg::OFS_PERIOD:
                        nxt_st.rdata = 32'(cur_ff.period);
                    bridge_pwm_pkg::OFS_DUTY:    nxt_st.rdata = 32'(cur_ff.duty);
                    bridge_pwm_pkg::OFS_STATUS:
                        nxt_st.rdata = 32'({cur_ff.count, cur_ff.fw_live,
                                            cur_ff.dstate[1], cur_ff.running});
                    default:                     nxt_st.rdata = bridge_pwm_pkg::UNMAPPED_RD;
                endcase
            end
        end
        // a write lands only at the accepting edge, never while waitrequest is high
        if (write && cur_ff.ack) begin
            begin
                case (address)
                    bridge_pwm_pkg::OFS_CONTROL:
                        nxt_st.control = (cur_ff.control & ~wmask) | (writedata & wmask);
                    bridge_pwm_pkg::OFS_PERIOD:
                        nxt_st.period = PERIOD_WIDTH'((32'(cur_ff.period) & ~wmask)
                                                     | (writedata & wmask));
                    bridge_pwm_pkg::OFS_DUTY:
                        nxt_st.duty = PERIOD_WIDTH'((32'(cur_ff.duty) & ~wmask)
                                                   | (writedata & wmask));
                    default: ;
                endcase
            end
        end
        // registered so the pin comes straight from a flop; high while idle,
        // which the avalon protocol allows for a slave with a fixed wait state
        nxt_st.waitreq = ~nxt_st.ack;

        // prescaled period timer
        // the count runs from zero up to the period value and wraps, so a
        // period value of p gives p+1 timer steps per pwm period
        nxt_st.presc = presc_tick ? 8'h00 : cur_ff.presc + 8'h01;
        if (presc_tick) begin
            nxt_st.count = period_end ? '0 : cur_ff.count + PERIOD_WIDTH'(1);
        end

        // direction sequencer and enable gating
        // idle: waits for a period wrap after enable, then latches duty and runs
        // run: duty is relatched at every wrap so a new duty never cuts a pulse
        // turn: entered the clock after the direction bit flips in full-bridge;
        //   the modulated leg is held off and the held leg already swapped, and
        //   modulation restarts only at the next wrap
        // limitation: a reversal at high duty can still shoot through a slow
        //   bridge; software is expected to lower duty for one period first
        // clearing enable drops straight back to idle with all legs inactive
        if (!enable) begin
            nxt_st.running = 1'b0;
            nxt_st.dstate  = bridge_pwm_pkg::DIR_IDLE;
        end else begin
            case (cur_ff.dstate)
                bridge_pwm_pkg::DIR_IDLE: begin
                    if (period_end) begin // wait for a fresh period
                        nxt_st.running   = 1'b1;
                        nxt_st.fw_live   = want_fw;
                        nxt_st.duty_live = cur_ff.duty;
                        nxt_st.dstate    = bridge_pwm_pkg::DIR_RUN;
                    end
                end
                bridge_pwm_pkg::DIR_RUN: begin
                    if (full_mode && (want_fw != cur_ff.fw_live)) begin
                        // kill the modulated leg and swap held leg now
                        nxt_st.fw_live = want_fw;
                        nxt_st.dstate  = bridge_pwm_pkg::DIR_TURN;
                    end else if (period_end) begin
                        nxt_st.duty_live = cur_ff.duty;
                    end
                end
                bridge_pwm_pkg::DIR_TURN: begin
                    if (period_end) begin // resume at next period start
                        nxt_st.duty_live = cur_ff.duty;
                        nxt_st.dstate    = bridge_pwm_pkg::DIR_RUN;
                    end
                end
                default: nxt_st.dstate = bridge_pwm_pkg::DIR_IDLE;
            endcase
        end

        // pins: apply polarity, release unused ones
        nxt_st.pin  = level ^ {pol[1], pol[0], pol[1], pol[0]};
        nxt_st.oe_b = ~(used & pin_dir); // pin enabled only when software sets it
    end

    // state register
    // reset leaves every pin released and inactive, the bus idle with
    // waitrequest high, and the timer at zero so the first period is full
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cur_ff           <= '0;
            cur_ff.control   <= bridge_pwm_pkg::CONTROL_RST;
            cur_ff.period    <= PERIOD_WIDTH'(bridge_pwm_pkg::PERIOD_RST);
            cur_ff.duty      <= PERIOD_WIDTH'(bridge_pwm_pkg::DUTY_RST);
            cur_ff.dstate    <= bridge_pwm_pkg::DIR_IDLE;
            cur_ff.oe_b      <= 4'hf;
            cur_ff.waitreq   <= 1'b1;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // outputs straight from the state flops
    // nothing here is decoded after the flops, so pin timing does not depend
    // on the bus or on the arrangement logic settling
    assign readdata        = cur_ff.rdata;
    assign waitrequest     = cur_ff.waitreq;
    assign pwm_output_a    = cur_ff.pin[0];
    assign pwm_output_b    = cur_ff.pin[1];
    assign pwm_output_c    = cur_ff.pin[2];
    assign pwm_output_d    = cur_ff.pin[3];
    assign pwm_output_oe_b = cur_ff.oe_b;

endmodule // bridge_pwm

//--- bridge_pwm_properties.sv
// concurrent checks on the bridge pwm stage: bus answer, pin release, bridge legs
// assumes full byte lanes on control writes and polarity bits clear where legs are judged
`timescale 1ns/1ps
module bridge_pwm_checker #(
    parameter int PERIOD_WIDTH = bridge_pwm_pkg::DUTY_BITS
) (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // avalon-mm slave
    input wire logic [3:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // pwm pins
    input wire logic        pwm_output_a,
    input wire logic        pwm_output_b,
    input wire logic        pwm_output_c,
    input wire logic        pwm_output_d,
    input wire logic [3:0]  pwm_output_oe_b
);
    logic [15:0] ctl_ff;
    wire logic [1:0] arr = ctl_ff[2:1];
    wire logic       quiet = (ctl_ff[5:4] == 2'h0);

    // shadow of control, taken at the acknowledge edge so it changes at the same edge as the design
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctl_ff <= 16'h0000;
        end else if (write && !waitrequest && address == bridge_pwm_pkg::OFS_CONTROL) begin
            ctl_ff <= writedata[15:0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    a_read_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("readdata moved without a read");
    a_reset_pins: assert property ($rose(rst_b) |-> pwm_output_oe_b == 4'hf)
        else $error("pins driven out of reset");
    a_single_release: assert property ($stable(ctl_ff) && arr == bridge_pwm_pkg::ARR_SINGLE
        |=> pwm_output_oe_b[3:1] == 3'h7) else $error("single drives b c d");
    a_half_release: assert property ($stable(ctl_ff) && arr == bridge_pwm_pkg::ARR_HALF
        |=> pwm_output_oe_b[3:2] == 2'h3) else $error("half drives c d");
    a_dir_gate: assert property ($stable(ctl_ff) && !ctl_ff[12] |=> pwm_output_oe_b[0])
        else $error("pin a driven without direction bit");
    a_fw_legs: assert property ($stable(ctl_ff) && quiet && arr == bridge_pwm_pkg::ARR_FULL_FW
        |=> !pwm_output_b && !pwm_output_c) else $error("forward legs wrong");
    a_rv_legs: assert property ($stable(ctl_ff) && quiet && arr == bridge_pwm_pkg::ARR_FULL_RV
        |=> !pwm_output_a && !pwm_output_d) else $error("reverse legs wrong");
    a_no_shoot: assert property (quiet && ctl_ff[1] |-> !(pwm_output_a && pwm_output_b)
        && !(pwm_output_c && pwm_output_d)) else $error("leg shorted");
    a_turn_swap: assert property (quiet && ctl_ff[0] && arr == bridge_pwm_pkg::ARR_FULL_RV
        && $past(arr) == bridge_pwm_pkg::ARR_FULL_FW |-> ##[0:2] (pwm_output_c && !pwm_output_a
        && !pwm_output_d)) else $error("turn did not swap legs");
endmodule // bridge_pwm_checker

bind bridge_pwm bridge_pwm_checker #(.PERIOD_WIDTH(PERIOD_WIDTH)) u_chk (.clock(clock),
    .rst_b(rst_b), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pwm_output_a(pwm_output_a), .pwm_output_b(pwm_output_b), .pwm_output_c(pwm_output_c),
    .pwm_output_d(pwm_output_d), .pwm_output_oe_b(pwm_output_oe_b));

//--- bridge_switch_model.sv
// power bridge model: four switches, a and b on one leg, c and d on the other
// assumes active-high pins; a released pin leaves its switch open
`timescale 1ns/1ps
module bridge_switch_model (
    // clock
    input  wire logic       clock,
    // pins from the stage, bit0 a .. bit3 d
    input  wire logic [3:0] pin_level,
    input  wire logic [3:0] pin_oe_b,
    // shorts seen, for the bench
    output int              shoot_count
);
    wire logic [3:0] sw_on = pin_level & ~pin_oe_b;

    int              shorts = 0;

    // no dead band is given, so both switches of a leg closed is a short
    always @(posedge clock) begin
        if ((sw_on[0] && sw_on[1]) || (sw_on[2] && sw_on[3])) begin
            shorts <= shorts + 1;
        end
    end
    assign shoot_count = shorts;
endmodule // bridge_switch_model

//--- tb_top.sv
// testbench for the bridge pwm stage: register access, pulse timing, direction turn
// assumes the checker is bound in and the switch model watches the pins
`timescale 1ns/1ps
module tb_top;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic [31:0] readdata;
    logic        waitrequest;
    wire  [3:0]  pins;
    logic [3:0]  oe_b;
    int          shoot_count;
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [31:0] rd;
    int          hi;
    int          lo;

    always #2 clock = ~clock;

    bridge_pwm dut (.clock(clock), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pwm_output_a(pins[0]), .pwm_output_b(pins[1]),
        .pwm_output_c(pins[2]), .pwm_output_d(pins[3]), .pwm_output_oe_b(oe_b));
    bridge_switch_model sw (.clock(clock), .pin_level(pins), .pin_oe_b(oe_b),
        .shoot_count(shoot_count));

    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer; held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge clock);
        address <= adr;
        writedata <= wd;
        write <= wr;
        read <= ~wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // time the first whole pulse at level lvl on pin i and the gap after it
    task automatic pulse(input int i, input logic lvl);
        hi = 0;
        lo = 0;
        @(negedge clock);
        while (pins[i] !== ~lvl) @(negedge clock);
        while (pins[i] !== lvl) @(negedge clock);
        while (pins[i] === lvl) begin
            hi++;
            @(negedge clock);
        end
        while (pins[i] !== lvl) begin
            lo++;
            @(negedge clock);
        end
    endtask
    task automatic test_regs();
        chk_word("oe_b after reset", 32'hf, 32'(oe_b));
        bus(1'b0, bridge_pwm_pkg::OFS_PERIOD, 32'h0);
        chk_word("period reset", 32'h3ff, rd);
        bus(1'b0, 4'h2, 32'h0);
        chk_word("unmapped read", 32'h0, rd);
        bus(1'b0, bridge_pwm_pkg::OFS_CONTROL, 32'h0);
        chk_word("control reset", 32'h0, rd);
        bus(1'b0, bridge_pwm_pkg::OFS_STATUS, 32'h0);
        chk_word("status idle", 32'h0, rd & 32'h7);
        bus(1'b1, bridge_pwm_pkg::OFS_DUTY, 32'hffff_ffff);
        bus(1'b0, bridge_pwm_pkg::OFS_DUTY, 32'h0);
        chk_word("duty width", 32'h3ff, rd);
        $display("test regs done");
    endtask
    // period 9 gives ten counts; duty 3 keeps three of them active
    task automatic test_single();
        bus(1'b1, bridge_pwm_pkg::OFS_PERIOD, 32'h9);
        bus(1'b1, bridge_pwm_pkg::OFS_DUTY, 32'h3);
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf001); // pins set as outputs
        pulse(0, 1'b1);
        chk_word("single first high", 32'd3, 32'(hi));
        chk_word("single low", 32'd7, 32'(lo));
        chk_word("single oe_b", 32'he, 32'(oe_b));
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf011);
        pulse(0, 1'b0);
        chk_word("inverted active", 32'd3, 32'(hi));
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf101);
        pulse(0, 1'b1);
        chk_word("prescaled high", 32'd12, 32'(hi));
        chk_word("prescaled low", 32'd28, 32'(lo));
        $display("test single done");
    endtask
    task automatic test_half();
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf005);
        pulse(0, 1'b1);
        for (int n = 0; n < 10; n++) begin
            @(negedge clock);
            chk_word("half pair", {30'h0, ~pins[0], pins[0]}, {30'h0, pins[1:0]});
        end
        chk_word("half oe_b", 32'hc, 32'(oe_b));
        $display("test half done");
    endtask
    // duty stays at three tenths, low enough to turn without a short
    task automatic test_full();
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf003);
        pulse(3, 1'b1);
        chk_word("forward d high", 32'd3, 32'(hi));
        chk_word("forward held", 32'h1, 32'(pins[2:0]));
        chk_word("full oe_b", 32'h0, 32'(oe_b));
        bus(1'b1, bridge_pwm_pkg::OFS_CONTROL, 32'hf007);
        repeat (3) @(negedge clock);
        chk_word("turn legs", 32'h4, 32'(pins));
        pulse(1, 1'b1);
        chk_word("reverse b high", 32'd3, 32'(hi));
        chk_word("reverse c held", 32'h4, 32'(pins & 4'hd));
        chk_word("no shorts", 32'd0, 32'(shoot_count));
        bus(1'b0, bridge_pwm_pkg::OFS_STATUS, 32'h0);
        chk_word("status reverse run", 32'h1, rd & 32'h7);
        $display("test full done");
    endtask

    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        test_regs();
        test_single();
        test_half();
        test_full();
        end_of_test();
    end
endmodule // tb_top
